//--- src/bsr_top.sv
module bsr_top (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_b,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic [1:0]               hresp,
    // abort events from the bus engine, one-cycle pulses
    input  wire bsr_pkg::bsr_events_t events,
    // strap pin
    input  wire logic                select_timing_strap,
    // interrupt
    output logic                     irq
);

    typedef struct packed {
        bsr_pkg::bsr_fsm_t               fsm;
        logic                            wr;
        bsr_pkg::bsr_sel_t               sel;
        logic                            hreadyout;
        logic [31:0]                     hrdata;
        logic [1:0]                      hresp;
        logic [bsr_pkg::FLAG_W-1:0]      mask;
        logic                            irq;
    } bsr_top_st_t;

    localparam bsr_top_st_t ST_RST = '{
        fsm:       bsr_pkg::ST_IDLE,
        wr:        1'b0,
        sel:       bsr_pkg::SEL_NONE,
        hreadyout: 1'b1,
        hrdata:    bsr_pkg::RDATA_RST,
        hresp:     bsr_pkg::RESP_OKAY,
        mask:      bsr_pkg::MASK_RST,
        irq:       1'b0
    };

    bsr_top_st_t                st_q;
    bsr_top_st_t                st_d;
    logic [bsr_pkg::FLAG_W-1:0] flags;
    logic [bsr_pkg::FLAG_W-1:0] clr;
    logic [1:0]                 timing;
    logic                       strap_level;
    logic [bsr_pkg::STATUS_W-1:0] status_now;
    logic                       accept;

    // ------------------------------------------------------------------
    // sub-blocks
    // ------------------------------------------------------------------
    bsr_strap_latch u_strap (
        .core_clk    (core_clk),
        .rst_b       (rst_b),
        .strap       (select_timing_strap),
        .strap_level (strap_level),
        .timing      (timing)
    );

    // event pulses go straight to the set side
    bsr_w1c_flags #(
        .W (bsr_pkg::FLAG_W)
    ) u_flags (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .set      (events),
        .clr      (clr),
        .flags    (flags)
    );

    // ------------------------------------------------------------------
    // register read view
    // ------------------------------------------------------------------
    // reserved and constant bits are fixed inside status_word
    assign status_now = bsr_pkg::status_word(flags, timing);
    assign accept     = hsel & htrans[1] & hready;

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    // one wait state: write data and read view both settle in the busy
    // cycle, so a read right behind a write sees the write's effect
    always_comb begin
        st_d       = st_q;
        st_d.hresp = bsr_pkg::RESP_OKAY;
        clr        = '0;
        unique case (st_q.fsm)
            bsr_pkg::ST_IDLE: begin
                st_d.hreadyout = 1'b1;
                if (accept) begin
                    st_d.fsm       = bsr_pkg::ST_BUSY;
                    st_d.hreadyout = 1'b0;
                    st_d.wr        = hwrite;
                    st_d.sel       = bsr_pkg::reg_sel(
                                         haddr[bsr_pkg::DEC_W-1:0]);
                end
            end
            bsr_pkg::ST_BUSY: begin
                st_d.fsm       = bsr_pkg::ST_IDLE;
                st_d.hreadyout = 1'b1;
                if (st_q.wr) begin
                    // status writes only clear, mask writes load; fbb and timing have no write path
                    if (st_q.sel == bsr_pkg::SEL_STATUS) begin
                        clr = hwdata[bsr_pkg::FLAG_MSB:
                                     bsr_pkg::FLAG_LSB];
                    end
                    if (st_q.sel == bsr_pkg::SEL_MASK) begin
                        st_d.mask =
                            hwdata[bsr_pkg::FLAG_MSB:bsr_pkg::FLAG_LSB];
                    end
                end else begin
                    // reads touch nothing but the data register
                    st_d.hrdata = '0;
                    unique case (st_q.sel)
                        bsr_pkg::SEL_STATUS:
                            st_d.hrdata[bsr_pkg::STATUS_W-1:0] = status_now;
                        bsr_pkg::SEL_STRAP:
                            st_d.hrdata[bsr_pkg::STRAP_BIT] = strap_level;
                        bsr_pkg::SEL_MASK:
                            st_d.hrdata[bsr_pkg::FLAG_MSB:bsr_pkg::FLAG_LSB] =
                                st_q.mask;
                        bsr_pkg::SEL_NONE: ;
                    endcase
                end
            end
        endcase
        st_d.irq = |(flags & st_q.mask);
        if (!rst_b) begin
            st_d = ST_RST;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
    end

    assign hreadyout = st_q.hreadyout;
    assign hrdata    = st_q.hrdata;
    assign hresp     = st_q.hresp;
    assign irq       = st_q.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    logic rd_status;
    logic rd_strap;
    logic wr_status;
    logic irq_src;
    assign rd_status = (st_q.fsm == bsr_pkg::ST_BUSY) && !st_q.wr
                       && (st_q.sel == bsr_pkg::SEL_STATUS);
    assign rd_strap  = (st_q.fsm == bsr_pkg::ST_BUSY) && !st_q.wr
                       && (st_q.sel == bsr_pkg::SEL_STRAP);
    assign wr_status = (st_q.fsm == bsr_pkg::ST_BUSY) && st_q.wr
                       && (st_q.sel == bsr_pkg::SEL_STATUS);
    assign irq_src   = |(flags & st_q.mask);

    property p_rd_pure;
        (st_q.fsm == bsr_pkg::ST_BUSY) && !st_q.wr && (events == '0)
            |=> $stable(flags);
    endproperty
    a_rd_pure: assert property (p_rd_pure)
        else $error("status read disturbed the flags");

    property p_rd_value;
        rd_status |=> hrdata[15:0] == $past(status_now) && hrdata[31:16] == '0;
    endproperty
    a_rd_value: assert property (p_rd_value)
        else $error("status read returned a stale word");

    property p_no_set;
        st_q.wr && (st_q.fsm == bsr_pkg::ST_BUSY) && (events == '0)
            |=> (flags & ~$past(flags)) == '0;
    endproperty
    a_no_set: assert property (p_no_set)
        else $error("host write set a status flag");

    property p_w1c;
        wr_status && hwdata[bsr_pkg::FLAG_LSB] && !events.tgt_abort_sig
            ##1 1'b1 |-> !flags[0];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("written one did not clear bit 11");

    property p_keep;
        wr_status && !hwdata[bsr_pkg::FLAG_MSB] && flags[2] |=> flags[2];
    endproperty
    a_keep: assert property (p_keep)
        else $error("written zero cleared bit 13");

    property p_rsvd_fbb;
        rd_status |=> hrdata[6:0] == 7'h00 && !hrdata[8] && hrdata[7]
                      && hrdata[15:14] == 2'h0;
    endproperty
    a_rsvd_fbb: assert property (p_rsvd_fbb)
        else $error("reserved or fast back-to-back bit wrong");

    property p_strap_load;
        disable iff (1'b0)
        !rst_b ##1 rst_b |-> timing == ($past(select_timing_strap)
                                       ? 2'h2 : 2'h1);
    endproperty
    a_strap_load: assert property (p_strap_load)
        else $error("timing field not loaded from strap");

    property p_timing_hold;
        $past(rst_b) |-> $stable(timing) && timing != bsr_pkg::TIM_RSVD
                         && timing != bsr_pkg::TIM_FAST;
    endproperty
    a_timing_hold: assert property (p_timing_hold)
        else $error("timing field changed or took a bad code");

    property p_readback;
        rd_strap |=> hrdata == {31'h0, strap_level}
                     && hrdata[0] == (timing == bsr_pkg::TIM_SLOW);
    endproperty
    a_readback: assert property (p_readback)
        else $error("strap readback mismatch");

    property p_ev_sig;
        events.tgt_abort_sig ##1 !clr[0] |-> flags[0] [*2];
    endproperty
    a_ev_sig: assert property (p_ev_sig)
        else $error("signaled target-abort not held");

    property p_ev_rcv;
        events.tgt_abort_rcv |=> flags[1];
    endproperty
    a_ev_rcv: assert property (p_ev_rcv)
        else $error("received target-abort not flagged");

    property p_ev_mst;
        events.mst_abort_rcv |=> flags[2];
    endproperty
    a_ev_mst: assert property (p_ev_mst)
        else $error("master-abort not flagged");

    property p_irq;
        1'b1 |=> irq == $past(irq_src);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt does not follow masked flags");

    property p_wait;
        accept && hreadyout |=> !hreadyout ##1 hreadyout;
    endproperty
    a_wait: assert property (p_wait)
        else $error("bus answer not one wait state");

    property p_okay;
        1'b1 |-> hresp == bsr_pkg::RESP_OKAY;
    endproperty
    a_okay: assert property (p_okay)
        else $error("bus response not okay");

    property p_rd_none;
        (st_q.fsm == bsr_pkg::ST_BUSY) && !st_q.wr
            && (st_q.sel == bsr_pkg::SEL_NONE) |=> hrdata == 32'h0000_0000;
    endproperty
    a_rd_none: assert property (p_rd_none)
        else $error("unmapped read returned data");

    property p_clr_gate;
        clr != '0 |-> wr_status;
    endproperty
    a_clr_gate: assert property (p_clr_gate)
        else $error("flag clear outside a status write");

    // read data must stand until the next read completes
    property p_hold_rdata;
        !((st_q.fsm == bsr_pkg::ST_BUSY) && !st_q.wr) |=> $stable(hrdata);
    endproperty
    a_hold_rdata: assert property (p_hold_rdata)
        else $error("read data changed without a read");

    // ------------------------------------------------------------------
    // coverage
    // ------------------------------------------------------------------
    c_rd_status: cover property (rd_status ##1 hrdata[bsr_pkg::FLAG_LSB]);
    c_clear:     cover property (flags[1] ##1 wr_status ##1 !flags[1]);
    c_irq:       cover property (!irq ##1 irq);
    c_race:      cover property (wr_status && events.mst_abort_rcv
                                 && hwdata[bsr_pkg::FLAG_MSB]);
    c_strap_hi:  cover property (timing == bsr_pkg::TIM_SLOW);

endmodule // bsr_top

//--- src/bsr_pkg.sv
package bsr_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, low address bits only)
    // ------------------------------------------------------------------
    localparam int unsigned DEC_W      = 8;
    localparam logic [7:0]  STATUS_OFF = 8'h00;
    localparam logic [7:0]  STRAP_OFF  = 8'h04;
    localparam logic [7:0]  MASK_OFF   = 8'h08;

    // ------------------------------------------------------------------
    // field layout of bus_status_word
    // ------------------------------------------------------------------
    localparam int unsigned STATUS_W   = 16;
    localparam int unsigned FBB_BIT    = 7;
    localparam int unsigned TIMING_LSB = 9;
    localparam int unsigned TIMING_MSB = 10;
    localparam int unsigned FLAG_LSB   = 11;
    localparam int unsigned FLAG_MSB   = 13;
    localparam int unsigned FLAG_W     = 3;
    localparam int unsigned STRAP_BIT  = 0;

    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic              FBB_VAL    = 1'b1;
    localparam logic [FLAG_W-1:0] FLAG_RST   = 3'h0;
    localparam logic [FLAG_W-1:0] MASK_RST   = 3'h0;
    localparam logic [31:0]       RDATA_RST  = 32'h0000_0000;
    localparam logic [1:0]        TIM_FAST   = 2'h0;
    localparam logic [1:0]        TIM_MEDIUM = 2'h1;
    localparam logic [1:0]        TIM_SLOW   = 2'h2;
    localparam logic [1:0]        TIM_RSVD   = 2'h3;
    localparam logic [1:0]        RESP_OKAY  = 2'h0;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        SEL_NONE   = 4'h1,
        SEL_STATUS = 4'h2,
        SEL_STRAP  = 4'h4,
        SEL_MASK   = 4'h8
    } bsr_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_BUSY = 2'h2
    } bsr_fsm_t;

    // bit order matches the flag field, msb first
    typedef struct packed {
        logic mst_abort_rcv;
        logic tgt_abort_rcv;
        logic tgt_abort_sig;
    } bsr_events_t;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic bsr_sel_t reg_sel(input logic [DEC_W-1:0] a);
        unique case (a)
            STATUS_OFF: reg_sel = SEL_STATUS;
            STRAP_OFF:  reg_sel = SEL_STRAP;
            MASK_OFF:   reg_sel = SEL_MASK;
            default:    reg_sel = SEL_NONE;
        endcase
    endfunction

    function automatic logic [1:0] timing_code(input logic strap);
        timing_code = strap ? TIM_SLOW : TIM_MEDIUM;
    endfunction

    function automatic logic [STATUS_W-1:0] status_word(
        input logic [FLAG_W-1:0] flags,
        input logic [1:0]        timing
    );
        status_word                        = '0;
        status_word[FBB_BIT]               = FBB_VAL;
        status_word[TIMING_MSB:TIMING_LSB] = timing;
        status_word[FLAG_MSB:FLAG_LSB]     = flags;
    endfunction

endpackage

//--- src/bsr_strap_latch.sv
module bsr_strap_latch (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    // strap pin
    input  wire logic       strap,
    // captured values
    output logic            strap_level,
    output logic [1:0]      timing
);

    typedef struct packed {
        logic level;
    } bsr_strap_st_t;

    bsr_strap_st_t st_q;
    bsr_strap_st_t st_d;

    // ------------------------------------------------------------------
    // capture
    // ------------------------------------------------------------------
    // follows the pin while reset is held, frozen from the release on
    always_comb begin
        st_d = st_q;
        if (!rst_b) begin
            st_d.level = strap;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
    end

    assign strap_level = st_q.level;
    assign timing      = bsr_pkg::timing_code(st_q.level);

endmodule // bsr_strap_latch

//--- src/bsr_w1c_flags.sv
module bsr_w1c_flags #(
    parameter int unsigned W = 3
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // set and clear
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // state
    output logic [W-1:0]      flags
);

    typedef struct packed {
        logic [W-1:0] flags;
    } bsr_w1c_st_t;

    bsr_w1c_st_t  st_q;
    bsr_w1c_st_t  st_d;
    logic [W-1:0] nxt;

    // ------------------------------------------------------------------
    // per-bit update
    // ------------------------------------------------------------------
    // set beats a clear landing in the same cycle
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign nxt[i] = set[i] | (st_q.flags[i] & ~clr[i]);
    end

    always_comb begin
        st_d.flags = nxt;
        if (!rst_b) begin
            st_d.flags = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        st_q <= st_d;
    end

    assign flags = st_q.flags;

endmodule // bsr_w1c_flags

//--- sim/bsr_engine_model.sv
module bsr_engine_model (
    // clock
    input  wire logic            core_clk,
    // abort events toward the status block
    output bsr_pkg::bsr_events_t events
);
    timeunit 1ns;
    timeprecision 1ps;

    initial events <= '0;

    // one-cycle pulse per abort, as the bus engine raises it
    task automatic fire(input int idx);
        @(posedge core_clk);
        events <= bsr_pkg::bsr_events_t'(3'h1 << idx);
        @(posedge core_clk);
        events <= '0;
    endtask
endmodule // bsr_engine_model

//--- sim/bus_status_register_tb.sv
module bus_status_register_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LIMIT = 6000;

    logic                 core_clk;
    logic                 rst_b;
    logic                 hsel;
    logic [31:0]          haddr;
    logic [1:0]           htrans;
    logic                 hwrite;
    logic [2:0]           hsize;
    logic [31:0]          hwdata;
    logic                 hreadyout;
    logic [31:0]          hrdata;
    logic [1:0]           hresp;
    bsr_pkg::bsr_events_t events;
    logic                 strap;
    logic                 irq;
    logic                 rdy_s;
    logic [31:0]          rdata_s;
    logic [1:0]           resp_s;
    int                   n_errors  = 0;
    int                   tests_run = 0;
    int                   cycles    = 0;

    bsr_top u_dut (
        .core_clk            (core_clk),
        .rst_b               (rst_b),
        .hsel                (hsel),
        .haddr               (haddr),
        .htrans              (htrans),
        .hwrite              (hwrite),
        .hsize               (hsize),
        .hwdata              (hwdata),
        .hready              (hreadyout),
        .hreadyout           (hreadyout),
        .hrdata              (hrdata),
        .hresp               (hresp),
        .events              (events),
        .select_timing_strap (strap),
        .irq                 (irq)
    );

    bsr_engine_model u_eng (
        .core_clk (core_clk),
        .events   (events)
    );

    // ------------------------------------------------------------------
    // clock, time zero values, timeout
    // ------------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    initial begin
        rst_b  <= 1'b0;
        hsel   <= 1'b0;
        haddr  <= 32'h0000_0000;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hsize  <= 3'h2;
        hwdata <= 32'h0000_0000;
        strap  <= 1'b0;
    end

    // settled copies, so a rising edge sees the value it samples
    always @(negedge core_clk) begin
        rdy_s   = hreadyout;
        rdata_s = hrdata;
        resp_s  = hresp;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            $display("CHECK FAILED %0t timeout", $time);
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %0t %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    // single word transfer; waits on hready with no assumed latency
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge core_clk);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge core_clk);
        while (rdy_s !== 1'b1) @(posedge core_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge core_clk);
        while (rdy_s !== 1'b1) @(posedge core_clk);
        rd = rdata_s;
        check({30'h0, resp_s}, 32'h0, "response");
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] unused;
        xfer(1'b1, a, d, unused);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0, d);
    endtask

    task automatic settle_irq(input logic exp, input string what);
        repeat (3) @(posedge core_clk);
        #1;
        check({31'h0, irq}, {31'h0, exp}, what);
    endtask

    function automatic logic [31:0] dflt(input logic s);
        return 32'h0000_0080 | (s ? 32'h0000_0400 : 32'h0000_0200);
    endfunction

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset(input logic s);
        logic [31:0] d;
        @(posedge core_clk);
        rst_b <= 1'b0;
        strap <= s;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        // strap moves right after reset; the field must not follow it
        strap <= ~s;
        @(posedge core_clk);
        #1;
        check({31'h0, irq}, 32'h0, "irq after reset");
        rd(bsr_pkg::STATUS_OFF, d);
        check(d, dflt(s), "status default");
        rd(bsr_pkg::STRAP_OFF, d);
        check({31'h0, d[0]}, {31'h0, s}, "strap readback");
        rd(bsr_pkg::MASK_OFF, d);
        check(d, 32'h0, "mask default");
    endtask

    task automatic t_readonly(input logic s);
        logic [31:0] d;
        wr(bsr_pkg::STATUS_OFF, 32'hffff_ffff);
        rd(bsr_pkg::STATUS_OFF, d);
        check(d, dflt(s), "status after ones");
        wr(bsr_pkg::STRAP_OFF, 32'hffff_fffe);
        rd(bsr_pkg::STRAP_OFF, d);
        check({31'h0, d[0]}, {31'h0, s}, "strap after write");
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c, d);
        check(d, 32'h0, "unmapped read");
    endtask

    task automatic t_flags(input logic s);
        logic [31:0] d;
        logic [31:0] exp;
        exp = dflt(s);
        for (int i = 0; i < 3; i++) begin
            u_eng.fire(i);
            exp = exp | (32'h0000_0800 << i);
            rd(bsr_pkg::STATUS_OFF, d);
            check(d, exp, "flag set");
        end
        rd(bsr_pkg::STATUS_OFF, d);
        check(d, exp, "second read");
        wr(bsr_pkg::STATUS_OFF, 32'h0000_0000);
        rd(bsr_pkg::STATUS_OFF, d);
        check(d, exp, "zero write");
        for (int i = 2; i >= 0; i--) begin
            wr(bsr_pkg::STATUS_OFF, 32'h0000_0800 << i);
            exp = exp & ~(32'h0000_0800 << i);
            rd(bsr_pkg::STATUS_OFF, d);
            check(d, exp, "one flag cleared");
        end
    endtask

    task automatic t_irq();
        logic [31:0] d;
        wr(bsr_pkg::MASK_OFF, 32'h0000_1000);
        rd(bsr_pkg::MASK_OFF, d);
        check(d, 32'h0000_1000, "mask readback");
        u_eng.fire(0);
        settle_irq(1'b0, "masked event");
        u_eng.fire(1);
        settle_irq(1'b1, "unmasked event");
        wr(bsr_pkg::MASK_OFF, 32'h0000_0000);
        settle_irq(1'b0, "mask off");
        wr(bsr_pkg::MASK_OFF, 32'h0000_3800);
        settle_irq(1'b1, "mask on");
        wr(bsr_pkg::STATUS_OFF, 32'h0000_1800);
        settle_irq(1'b0, "flags cleared");
        wr(bsr_pkg::MASK_OFF, 32'h0000_0000);
    endtask

    // ------------------------------------------------------------------
    // main sequence: second pass resets mid-run with the strap high
    // ------------------------------------------------------------------
    initial begin
        for (int s = 0; s < 2; s++) begin
            t_reset(1'(s));
            t_readonly(1'(s));
            t_flags(1'(s));
            t_irq();
        end
        report_and_stop();
    end
endmodule // bus_status_register_tb
